// >>> hdl/icc_channel.sv
// One capture channel: edge select, prescaler, buffer and event count
`include "icc_params.svh"

module icc_channel #(
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire icc_pkg::icc_ctrl_t ctrl,
  input wire icc_pkg::icc_power_t power,
  input wire icc_pkg::icc_timebase_t tb,
  input wire logic cap_pin,
  input wire logic rd_pop,
  output logic [15:0] rd_data,
  output logic [$clog2(DEPTH+1)-1:0] fill_level,
  output logic buf_not_empty_flag,
  output logic capture_overrun_flag,
  output logic irq_pulse
);
  localparam int CW = $clog2(DEPTH + 1);
  icc_pkg::icc_chan_st_t st_reg, st_next;
  icc_pkg::icc_mode_t mode;
  logic rise, fall, run_ok, edge_ev, hit, push, full, ev_ok;
  logic [15:0] stamp;

  assign mode = ctrl.capture_mode_sel;
  assign stamp = ctrl.timebase_select ? tb.timebase_a : tb.timebase_b;
  assign full = fill_level == CW'(DEPTH);

  always_comb begin
    st_next = st_reg;
    st_next.prev_pin = cap_pin;
    rise = cap_pin & ~st_reg.prev_pin;
    fall = ~cap_pin & st_reg.prev_pin;
    run_ok = !power.cpu_sleep
      && !(power.cpu_idle && ctrl.stop_in_idle_ctrl)
      && (ctrl.timebase_select ? tb.a_on : tb.b_on);
    unique case (mode)
      icc_pkg::ICC_BOTH: edge_ev = run_ok & (rise | fall);
      icc_pkg::ICC_FALL: edge_ev = run_ok & fall;
      icc_pkg::ICC_RISE: edge_ev = run_ok & rise;
      icc_pkg::ICC_RISE4:
        edge_ev = run_ok & rise & (st_reg.presc[1:0] == `ICC_DIV4_LAST);
      icc_pkg::ICC_RISE16:
        edge_ev = run_ok & rise & (st_reg.presc == `ICC_DIV16_LAST);
      icc_pkg::ICC_INTONLY: edge_ev = rise;
      icc_pkg::ICC_OFF, icc_pkg::ICC_UNUSED: edge_ev = 1'b0;
    endcase
    if (run_ok && rise && (mode == icc_pkg::ICC_RISE4
        || mode == icc_pkg::ICC_RISE16)) begin
      st_next.presc = st_reg.presc + 4'h1;
    end
    hit = edge_ev && mode != icc_pkg::ICC_INTONLY && !st_reg.lock;
    push = hit && !full;
    if (hit && full && mode != icc_pkg::ICC_BOTH) begin
      st_next.ov = 1'b1;
      st_next.lock = 1'b1;
    end
    if (st_reg.lock && fill_level == '0) begin
      st_next.lock = 1'b0;
    end
    ev_ok = push || (edge_ev && mode == icc_pkg::ICC_INTONLY)
      || (hit && mode == icc_pkg::ICC_BOTH);
    irq_pulse = 1'b0;
    if (ev_ok) begin
      if (mode == icc_pkg::ICC_BOTH || mode == icc_pkg::ICC_INTONLY
          || power.cpu_sleep) begin
        irq_pulse = 1'b1;
      end else if (st_reg.epi_cnt == ctrl.events_per_irq_sel) begin
        irq_pulse = 1'b1;
        st_next.epi_cnt = 2'h0;
      end else begin
        st_next.epi_cnt = st_reg.epi_cnt + 2'h1;
      end
    end
    if (mode == icc_pkg::ICC_OFF) begin
      st_next.presc = 4'h0;
      st_next.epi_cnt = 2'h0;
      st_next.ov = 1'b0;
      st_next.lock = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.prev_pin <= cap_pin;
    end else begin
      st_reg <= st_next;
    end
  end

  icc_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(push),
    .push_data(stamp),
    .pop(rd_pop),
    .head(rd_data),
    .count(fill_level)
  );

  assign buf_not_empty_flag = fill_level != '0;
  assign capture_overrun_flag = st_reg.ov;
endmodule

// >>> hdl/icc_fifo.sv
// Shift buffer holding captured time stamps, oldest word at the head
module icc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [CW-1:0] count;
  } icc_fifo_st_t;
  icc_fifo_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (pop && st_reg.count != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_next.words[i] = st_reg.words[i+1];
      end
      st_next.count = st_reg.count - 1'b1;
    end
    if (push && st_next.count != CW'(DEPTH)) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (CW'(i) == st_next.count) begin
          st_next.words[i] = push_data;
        end
      end
      st_next.count = st_next.count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign head = st_reg.words[0];
  assign count = st_reg.count;
endmodule

// >>> hdl/icc_params.svh
// Offsets, field positions and counts of the input capture block
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
`define ICC_CH_STRIDE 8'h08
`define ICC_BUF_OFS 8'h00
`define ICC_CON_OFS 8'h04
`define ICC_FLAG_OFS 8'h20
`define ICC_EN_OFS 8'h24
`define ICC_MODE_LSB 0
`define ICC_BNE_BIT 3
`define ICC_OV_BIT 4
`define ICC_EPI_LSB 5
`define ICC_TSEL_BIT 7
`define ICC_SIDL_BIT 13
`define ICC_FIFO_DEPTH 4
`define ICC_DIV4_LAST 2'h3
`define ICC_DIV16_LAST 4'hF
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2
`endif

// >>> hdl/icc_pkg.sv
// Types of the input capture block
package icc_pkg;
  typedef enum logic [2:0] {
    ICC_OFF = 3'h0, ICC_BOTH = 3'h1, ICC_FALL = 3'h2, ICC_RISE = 3'h3,
    ICC_RISE4 = 3'h4, ICC_RISE16 = 3'h5, ICC_UNUSED = 3'h6,
    ICC_INTONLY = 3'h7
  } icc_mode_t;
  typedef struct packed {
    logic stop_in_idle_ctrl;
    logic timebase_select;
    logic [1:0] events_per_irq_sel;
    icc_mode_t capture_mode_sel;
  } icc_ctrl_t;
  typedef struct packed {
    logic cpu_idle;
    logic cpu_sleep;
  } icc_power_t;
  typedef struct packed {
    logic [15:0] timebase_a;
    logic [15:0] timebase_b;
    logic a_on;
    logic b_on;
  } icc_timebase_t;
  typedef struct packed {
    logic prev_pin;
    logic [3:0] presc;
    logic [1:0] epi_cnt;
    logic ov;
    logic lock;
  } icc_chan_st_t;
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    icc_ctrl_t [3:0] channel_control_reg;
    logic [3:0] channel_irq_flag_reg;
    logic [3:0] channel_irq_enable_reg;
    logic wake;
  } icc_top_st_t;
endpackage

// >>> hdl/icc_top.sv
// Input capture block: four capture channels behind an AXI4-Lite slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`include "icc_params.svh"

module icc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] cap_pin,
  input wire icc_pkg::icc_timebase_t tb,
  input wire icc_pkg::icc_power_t power,
  output logic [3:0] channel_irq_flag,
  output logic wake_req
);
  icc_pkg::icc_top_st_t st_reg, st_next;
  logic [3:0] pop, irq_pulse, bne, ov, run_ok;
  logic [3:0][15:0] head;
  logic [3:0][2:0] fill;
  logic ar_fire, wr_go, rd_err, wr_err;
  logic [31:0] rd_word;

  // Control word as software sees it
  function automatic logic [15:0] con_word(
    input icc_pkg::icc_ctrl_t c,
    input logic b,
    input logic o
  );
    logic [15:0] w;
    w = 16'h0000;
    w[`ICC_MODE_LSB +: 3] = c.capture_mode_sel;
    w[`ICC_BNE_BIT] = b;
    w[`ICC_OV_BIT] = o;
    w[`ICC_EPI_LSB +: 2] = c.events_per_irq_sel;
    w[`ICC_TSEL_BIT] = c.timebase_select;
    w[`ICC_SIDL_BIT] = c.stop_in_idle_ctrl;
    return w;
  endfunction

  // Channel slots 0..3
  for (genvar g = 0; g < 4; g++) begin : g_ch
    icc_channel #(.DEPTH(`ICC_FIFO_DEPTH)) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(st_reg.channel_control_reg[g]),
      .power(power),
      .tb(tb),
      .cap_pin(cap_pin[g]),
      .rd_pop(pop[g]),
      .rd_data(head[g]),
      .fill_level(fill[g]),
      .buf_not_empty_flag(bne[g]),
      .capture_overrun_flag(ov[g]),
      .irq_pulse(irq_pulse[g])
    );
  end

  // Read address decode
  always_comb begin
    ar_fire = s_axi_arvalid && !st_reg.rvalid;
    pop = 4'h0;
    rd_word = 32'h0000_0000;
    rd_err = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (s_axi_araddr == 8'(`ICC_BUF_OFS + i * `ICC_CH_STRIDE)) begin
        rd_word = {16'h0000, head[i]};
        rd_err = 1'b0;
        pop[i] = ar_fire;
      end
      if (s_axi_araddr == 8'(`ICC_CON_OFS + i * `ICC_CH_STRIDE)) begin
        rd_word = {16'h0000,
          con_word(st_reg.channel_control_reg[i], bne[i], ov[i])};
        rd_err = 1'b0;
      end
    end
    if (s_axi_araddr == `ICC_FLAG_OFS) begin
      rd_word = {28'h0000000, st_reg.channel_irq_flag_reg};
      rd_err = 1'b0;
    end
    if (s_axi_araddr == `ICC_EN_OFS) begin
      rd_word = {28'h0000000, st_reg.channel_irq_enable_reg};
      rd_err = 1'b0;
    end
  end

  // Bus slave and register state
  always_comb begin
    st_next = st_reg;
    wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    wr_err = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (st_reg.aw_addr == 8'(`ICC_BUF_OFS + i * `ICC_CH_STRIDE)) begin
          wr_err = 1'b0;
        end
        if (st_reg.aw_addr == 8'(`ICC_CON_OFS + i * `ICC_CH_STRIDE)) begin
          wr_err = 1'b0;
          if (st_reg.w_strb[0]) begin
            st_next.channel_control_reg[i].capture_mode_sel =
              icc_pkg::icc_mode_t'(st_reg.w_data[`ICC_MODE_LSB +: 3]);
            st_next.channel_control_reg[i].events_per_irq_sel =
              st_reg.w_data[`ICC_EPI_LSB +: 2];
            st_next.channel_control_reg[i].timebase_select =
              st_reg.w_data[`ICC_TSEL_BIT];
          end
          if (st_reg.w_strb[1]) begin
            st_next.channel_control_reg[i].stop_in_idle_ctrl =
              st_reg.w_data[`ICC_SIDL_BIT];
          end
        end
      end
      if (st_reg.aw_addr == `ICC_FLAG_OFS) begin
        wr_err = 1'b0;
        if (st_reg.w_strb[0]) begin
          st_next.channel_irq_flag_reg =
            st_reg.channel_irq_flag_reg & ~st_reg.w_data[3:0];
        end
      end
      if (st_reg.aw_addr == `ICC_EN_OFS) begin
        wr_err = 1'b0;
        if (st_reg.w_strb[0]) begin
          st_next.channel_irq_enable_reg = st_reg.w_data[3:0];
        end
      end
      st_next.bresp = wr_err ? `ICC_RESP_SLVERR : `ICC_RESP_OKAY;
    end
    // Hardware set wins over software clear
    st_next.channel_irq_flag_reg =
      st_next.channel_irq_flag_reg | irq_pulse;
    if (ar_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_word;
      st_next.rresp = rd_err ? `ICC_RESP_SLVERR : `ICC_RESP_OKAY;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.wake = (power.cpu_idle || power.cpu_sleep)
      && |(st_next.channel_irq_flag_reg
      & st_next.channel_irq_enable_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign channel_irq_flag = st_reg.channel_irq_flag_reg;
  assign wake_req = st_reg.wake;

  // Checks
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      run_ok[i] = !power.cpu_sleep
        && !(power.cpu_idle
        && st_reg.channel_control_reg[i].stop_in_idle_ctrl)
        && (st_reg.channel_control_reg[i].timebase_select
        ? tb.a_on : tb.b_on);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  for (genvar g = 0; g < 4; g++) begin : g_chk
    a_fifo_depth_bound: assert property (
      (fill[g] <= 3'h4)
      and (fill[g] == 3'h4 && !pop[g] |=> fill[g] == 3'h4))
      else $error("buffer level out of range");
    a_not_empty_level: assert property (
      (bne[g] == (fill[g] != 3'h0))
      and ($rose(bne[g]) |-> $past(!pop[g])))
      else $error("not-empty flag wrong");
    a_read_oldest_word: assert property (
      ar_fire && pop[g] && bne[g]
      |=> st_reg.rdata == {16'h0000, $past(head[g])}
      && fill[g] <= $past(fill[g]))
      else $error("read did not return oldest word");
    a_overrun_on_full: assert property (
      (st_reg.channel_control_reg[g].capture_mode_sel == icc_pkg::ICC_FALL
      && $fell(cap_pin[g])
      || st_reg.channel_control_reg[g].capture_mode_sel == icc_pkg::ICC_RISE
      && $rose(cap_pin[g]))
      && run_ok[g] && fill[g] == 3'h4 && !ov[g] && !pop[g]
      |=> ov[g] && fill[g] == 3'h4)
      else $error("overrun not flagged on full buffer");
    a_both_no_overrun: assert property (
      st_reg.channel_control_reg[g].capture_mode_sel == icc_pkg::ICC_BOTH
      && !ov[g] |=> !ov[g])
      else $error("overrun raised in both-edges mode");
    a_both_every_edge: assert property (
      st_reg.channel_control_reg[g].capture_mode_sel == icc_pkg::ICC_BOTH
      && run_ok[g] && !ov[g] && $changed(cap_pin[g])
      |=> channel_irq_flag[g])
      else $error("both-edges capture missed its flag");
    a_stamp_timebase: assert property (
      st_reg.channel_control_reg[g].capture_mode_sel == icc_pkg::ICC_RISE
      && run_ok[g] && fill[g] == 3'h0 && !ov[g] && $rose(cap_pin[g])
      |=> head[g] == $past(st_reg.channel_control_reg[g].timebase_select
      ? tb.timebase_a : tb.timebase_b))
      else $error("captured value from wrong timer");
    a_sleep_intonly: assert property (
      power.cpu_sleep && $rose(cap_pin[g])
      && st_reg.channel_control_reg[g].capture_mode_sel
      == icc_pkg::ICC_INTONLY
      |=> channel_irq_flag[g])
      else $error("sleep edge did not raise flag");
    a_sleep_no_store: assert property (
      power.cpu_sleep && !pop[g] |=> fill[g] == $past(fill[g]))
      else $error("capture stored during sleep");
    a_flag_set_wins: assert property (
      irq_pulse[g] |=> channel_irq_flag[g])
      else $error("interrupt event lost");
  end

  a_wake_on_event: assert property (
    (power.cpu_idle || power.cpu_sleep) && $stable(power)
    && |(irq_pulse & st_reg.channel_irq_enable_reg)
    && !(wr_go && st_reg.aw_addr == `ICC_EN_OFS)
    |=> wake_req)
    else $error("enabled event did not wake");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");

  c_overrun: cover property ($rose(ov[0]));
  c_wake: cover property ($rose(wake_req));
  c_buf_read: cover property (ar_fire && pop[0] && bne[0]);
  c_both_flag: cover property (
    st_reg.channel_control_reg[1].capture_mode_sel == icc_pkg::ICC_BOTH
    && irq_pulse[1]);
endmodule

// >>> tb/icc_far_model.sv
// Far-side model: capture pins and the two time bases
module icc_far_model (
  input wire logic aclk,
  input wire logic [3:0] pin_req,
  input wire logic a_run,
  input wire logic b_run,
  output logic [3:0] cap_pin,
  output icc_pkg::icc_timebase_t tbv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cap_pin = 4'h0;
    tbv = 34'h0;
  end
  // Pins follow bench requests; timers count only while running
  always @(posedge aclk) begin
    cap_pin <= pin_req;
    tbv.a_on <= a_run;
    tbv.b_on <= b_run;
    if (a_run) tbv.timebase_a <= tbv.timebase_a + 16'h0001;
    if (b_run) tbv.timebase_b <= tbv.timebase_b + 16'h0101;
  end
endmodule

// >>> tb/icc_tb.sv
// Self-checking bench of the input capture block
`include "icc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req, a_run, b_run;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb, cap_pin, pin_req, channel_irq_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  icc_pkg::icc_timebase_t tbv;
  icc_pkg::icc_power_t power;
  int miscompares, check_count;
  logic [15:0] q[$];
  icc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cap_pin, .tb(tbv),
    .power, .channel_irq_flag, .wake_req);
  icc_far_model FAR (.aclk, .pin_req, .a_run, .b_run, .cap_pin, .tbv);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctl(logic [2:0] m, logic [1:0] e,
                                      logic t, logic s);
    return {18'h00000, s, 5'h00, t, e, 2'h0, m};
  endfunction
  // Whether pulse i since mode entry yields a capture
  function automatic logic hit(logic [2:0] m, int i);
    return m == 3'h4 ? i % 4 == 3 : m == 3'h5 ? i % 16 == 15 : 1'b1;
  endfunction
  function automatic logic [7:0] con(int c);
    return 8'(c) * `ICC_CH_STRIDE + `ICC_CON_OFS;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic done(string n);
    $display("test %s finished, mismatches so far %0d", n, miscompares);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic w(logic [7:0] a, logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(`ICC_RESP_OKAY), 32'(r));
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", 32'(`ICC_RESP_OKAY), 32'(r));
    chk(n, e, d);
  endtask
  task automatic set_pin(int c, logic v, logic t, output logic [15:0] s);
    @(posedge aclk);
    if (v) pin_req <= pin_req | (4'h1 << c);
    else pin_req <= pin_req & ~(4'h1 << c);
    @(posedge aclk);
    #1 s = t ? tbv.timebase_a : tbv.timebase_b;
  endtask
  task automatic pulse(int c, logic t, output logic [15:0] s,
                       output logic [15:0] f);
    set_pin(c, 1'b1, t, s);
    set_pin(c, 1'b0, t, f);
    repeat (2) @(posedge aclk);
  endtask
  // Pulses and queues the stamps that the mode should keep
  task automatic run(int c, logic [2:0] m, logic t, int p);
    logic [15:0] s, f;
    for (int i = 0; i < p; i++) begin
      pulse(c, t, s, f);
      if (hit(m, i)) q.push_back(m == 3'h2 ? f : s);
    end
  endtask
  task automatic drain(int c, logic [31:0] e);
    while (q.size() > 0)
      rdchk(8'(c) * `ICC_CH_STRIDE, {16'h0000, q.pop_front()}, "word");
    rdchk(con(c), e, "status after drain");
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    logic [2:0] ml [4];
    int np [4];
    int c, n;
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] s, f;
    ml = '{3'h2, 3'h3, 3'h4, 3'h5};
    np = '{3, 3, 16, 16};
    seed = 32'h0000EE8C;
    miscompares = 0;
    check_count = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    pin_req = 4'h0;
    power = 2'h0;
    a_run = 1'b1;
    b_run = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) rdchk(con(k), 32'h0, "ctl reset");
    rdchk(`ICC_FLAG_OFS, 32'h0, "flag reset");
    rd(8'h28, d, r);
    chk("unmapped rresp", 32'(`ICC_RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    wr(8'h30, 32'hFFFFFFFF, r);
    chk("unmapped bresp", 32'(`ICC_RESP_SLVERR), 32'(r));
    done("reset");
    repeat (8) begin
      d = rnd();
      c = int'(d[9:8]);
      t = d[0];
      n = 1 + int'(d[3:2]);
      w(con(c), ctl(3'h3, 2'h0, t, 1'b0));
      run(c, 3'h3, t, n);
      rdchk(con(c), ctl(3'h3, 2'h0, t, 1'b0) | 32'h8, "bne");
      drain(c, ctl(3'h3, 2'h0, t, 1'b0));
      w(con(c), 32'h0);
    end
    done("random");
    w(`ICC_FLAG_OFS, 32'hF);
    w(con(0), 32'h3);
    run(0, 3'h3, 1'b0, 4);
    for (int i = 0; i < 2; i++) pulse(0, 1'b0, s, f);
    rdchk(con(0), 32'h1B, "overrun set");
    rdchk(`ICC_BUF_OFS, {16'h0000, q.pop_front()}, "oldest");
    pulse(0, 1'b0, s, f);
    drain(0, 32'h13);
    w(con(0), 32'h0);
    rdchk(con(0), 32'h0, "overrun cleared");
    done("overrun");
    w(`ICC_FLAG_OFS, 32'hF);
    w(con(1), 32'hE1);
    for (int i = 0; i < 6; i++) begin
      set_pin(1, i % 2 == 0, 1'b1, s);
      if (i < 4) q.push_back(s);
      repeat (2) @(posedge aclk);
      chk("flag per edge", 32'h2, 32'(channel_irq_flag));
      w(`ICC_FLAG_OFS, 32'h2);
    end
    rdchk(con(1), 32'hE9, "both no overrun");
    drain(1, 32'hE1);
    w(con(1), 32'h0);
    done("both edges");
    for (int k = 0; k < 4; k++) begin
      w(con(2), {29'h0, ml[k]});
      run(2, ml[k], 1'b0, np[k]);
      drain(2, {29'h0, ml[k]});
      w(con(2), 32'h0);
    end
    w(con(2), 32'h4);
    run(2, 3'h4, 1'b0, 2);
    w(con(2), 32'h0);
    w(con(2), 32'h4);
    run(2, 3'h4, 1'b0, 4);
    drain(2, 32'h4);
    w(con(2), 32'h0);
    done("modes");
    for (int e = 0; e < 4; e++) begin
      w(`ICC_FLAG_OFS, 32'hF);
      w(con(0), ctl(3'h3, 2'(e), 1'b0, 1'b0));
      for (int i = 0; i <= e; i++) begin
        run(0, 3'h3, 1'b0, 1);
        chk("epi", 32'(i == e), 32'(channel_irq_flag[0]));
      end
      drain(0, ctl(3'h3, 2'(e), 1'b0, 1'b0));
      w(con(0), 32'h0);
    end
    done("events per interrupt");
    w(`ICC_FLAG_OFS, 32'hF);
    w(`ICC_EN_OFS, 32'h2);
    rdchk(`ICC_EN_OFS, 32'h2, "enable");
    power.cpu_idle <= 1'b1;
    w(con(1), 32'h3);
    run(1, 3'h3, 1'b0, 1);
    chk("idle wake", 32'h1, 32'(wake_req));
    drain(1, 32'h3);
    w(`ICC_FLAG_OFS, 32'hF);
    @(posedge aclk);
    chk("wake cleared", 32'h0, 32'(wake_req));
    w(con(1), 32'h2003);
    pulse(1, 1'b0, s, f);
    drain(1, 32'h2003);
    power.cpu_idle <= 1'b0;
    w(con(1), 32'h0);
    a_run <= 1'b0;
    b_run <= 1'b0;
    w(`ICC_FLAG_OFS, 32'hF);
    w(`ICC_EN_OFS, 32'h8);
    w(con(3), 32'h7);
    power.cpu_sleep <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) w(`ICC_EN_OFS, 32'h0);
      set_pin(3, i % 2 == 0, 1'b0, s);
      repeat (3) @(posedge aclk);
      chk("sleep flag", i % 2 == 0 ? 32'h8 : 32'h0,
          32'(channel_irq_flag));
      chk("sleep wake", 32'(i == 0), 32'(wake_req));
      w(`ICC_FLAG_OFS, 32'hF);
    end
    rdchk(con(3), 32'h7, "no capture asleep");
    w(con(2), 32'h4);
    run(2, 3'h4, 1'b0, 2);
    power.cpu_sleep <= 1'b0;
    a_run <= 1'b1;
    b_run <= 1'b1;
    run(2, 3'h4, 1'b0, 4);
    drain(2, 32'h4);
    w(con(2), 32'h0);
    done("power");
    tally_and_finish();
  end
endmodule
